/* src/dcc_params.svh */
// Register offsets, field positions and reset values of the comparator block
`ifndef DCC_PARAMS_SVH
`define DCC_PARAMS_SVH

`define DCC_OFS_CTRL0      5'h00
`define DCC_OFS_CTRL1      5'h04
`define DCC_OFS_STATUS     5'h08
`define DCC_OFS_MASK       5'h0c

`define DCC_BIT_CLAIM      7
`define DCC_BIT_POWER      6
`define DCC_BIT_INVERT     5
`define DCC_BIT_RESULT     4
`define DCC_BIT_OUT_PATH   3
`define DCC_BIT_HYST       0

`define DCC_CTRL_RESET     8'h81
`define DCC_CTRL_WMASK     8'he9
`define DCC_STATUS_RESET   2'h0
`define DCC_MASK_RESET     2'h0

`endif

/* src/dcc_pkg.sv */
// Types shared by the comparator control block
package dcc_pkg;

   typedef struct packed {
      logic       pin_claim;
      logic       power_on;
      logic       invert;
      logic       result;
      logic       out_path;
      logic [1:0] unused;
      logic       hyst_on;
   } dcc_ctrl_t;

   typedef struct packed {
      logic [1:0] pin_level;
      logic [1:0] port_ctrl;
      logic [1:0] port_data;
      logic [1:0] pullup_cfg;
   } dcc_pins_t;

   typedef enum logic [0:0] {
      DCC_IDLE,
      DCC_ANSWER
   } dcc_bus_state_t;

endpackage

/* src/dcc_sync.sv */
// Two flip-flop synchroniser for one asynchronous level
module dcc_sync
(
   // Clock and reset
   input  wire logic clock_in,
   input  wire logic rst_in,
   // Level
   input  wire logic level_in,
   output logic      level_out
);

   logic stage1;

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         stage1    <= 1'b0;
         level_out <= 1'b0;
      end
      else
      begin
         stage1    <= level_in;
         level_out <= stage1;
      end
   end

endmodule

/* src/dcc_channel.sv */
// One comparator channel: synchronised result, polarity and change pulse
module dcc_channel
(
   // Clock and reset
   input  wire logic             clock_in,
   input  wire logic             rst_in,
   // Control and raw analog result
   input  wire dcc_pkg::dcc_ctrl_t ctrl_in,
   input  wire logic             raw_in,
   // Stored result and its change
   output logic                  result_out,
   output logic                  change_out
);
   import dcc_pkg::*;

   logic raw_sync;
   logic next_result;

   dcc_sync u_sync
   (
      .clock_in  (clock_in),
      .rst_in    (rst_in),
      .level_in  (raw_in),
      .level_out (raw_sync)
   );

   // Switched-off comparator holds its last value
   always_comb
   begin
      next_result = result_out;
      if (ctrl_in.power_on)
         next_result = raw_sync ^ ctrl_in.invert;
   end

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
         result_out <= 1'b0;
      else
         result_out <= next_result;
   end

   // Flag on any change of the stored bit
   assign change_out = next_result != result_out;

endmodule

/* src/dcc_top.sv */
// Control, status and pin logic for two on-chip analog comparators
// Notes on behaviour
// - Polarity 0 stores the raw result, polarity 1 stores its inverse.
// - Result reads 1 for plus above minus at polarity 0, reversed at 1.
// - The result drives its output pin only for path 0 and pin claim 1.
// - The hysteresis bit turns the comparator hysteresis on and off.
// - Control bits two and one ignore writes and read as zero.
// - Pin claim gives both input pins to the comparator, pull-ups off.
// - Enable 0 powers the comparator down, enable 1 runs it.
// - Each result change sets the comparator flag and may interrupt.
// - A flag-setting change in sleep or idle with power on wakes the core.
// - Entering sleep or idle never switches a comparator off.
// - Claimed port reads give zero for control 1, port data for control 0.
// - Both control registers share layout and act independently.
//
// Chosen here: the register offsets and register access over Avalon-MM.
`include "dcc_params.svh"
module dcc_top
(
   // Clock and reset
   input  wire logic               clock_in,
   input  wire logic               rst_in,
   // Avalon-MM slave
   input  wire logic [4:0]         avs_address_in,
   input  wire logic               avs_read_in,
   input  wire logic               avs_write_in,
   input  wire logic [31:0]        avs_writedata_in,
   input  wire logic [3:0]         avs_byteenable_in,
   output logic [31:0]             avs_readdata_out,
   output logic                    avs_waitrequest_out,
   // Analog front end
   input  wire logic [1:0]         raw_result_in,
   output logic [1:0]              power_on_out,
   output logic [1:0]              hyst_on_out,
   // Shared pins, one group per comparator
   input  wire dcc_pkg::dcc_pins_t pins0_in,
   input  wire dcc_pkg::dcc_pins_t pins1_in,
   output logic [3:0]              port_read_out,
   output logic [3:0]              pullup_en_out,
   output logic [1:0]              result_pin_out,
   output logic [1:0]              result_pin_oe_out,
   // Core power state and events
   input  wire logic               low_power_in,
   output logic                    irq_out,
   output logic                    wake_out
);
   import dcc_pkg::*;

   dcc_ctrl_t      ctrl [1:0];
   dcc_pins_t      pins [1:0];
   dcc_bus_state_t bus_state;
   logic [1:0]     result;
   logic [1:0]     change;
   logic [1:0]     status;
   logic [1:0]     mask;
   logic [31:0]    next_readdata;
   logic           take;
   logic           take_wr;
   logic           take_rd;
   logic           load_rd;
   logic [1:0]     ctrl_sel;
   logic [1:0]     sw_set;
   logic [1:0]     rd_clr;

   assign pins[0] = pins0_in;
   assign pins[1] = pins1_in;

   // Decode of a byte address onto the control register index
   function automatic logic [1:0] ctrl_hit(input logic [4:0] addr);
      ctrl_hit = {addr == `DCC_OFS_CTRL1, addr == `DCC_OFS_CTRL0};
   endfunction

   // Every access waits exactly one cycle, answered in the second
   assign take    = bus_state == DCC_ANSWER;
   assign take_wr = take & avs_write_in;
   assign take_rd = take & avs_read_in;
   assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~take;
   assign load_rd  = (bus_state == DCC_IDLE) & avs_read_in;
   assign ctrl_sel = ctrl_hit(avs_address_in);

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
         bus_state <= DCC_IDLE;
      else
      begin
         case (bus_state)
            DCC_IDLE:
               if (avs_read_in | avs_write_in)
                  bus_state <= DCC_ANSWER;
            DCC_ANSWER:
               bus_state <= DCC_IDLE;
            default:
               bus_state <= DCC_IDLE;
         endcase
      end
   end

   genvar i;
   generate
      for (i = 0; i < 2; i++)
      begin : g_cmp
         // Each channel owns its register, never touched by the other
         always_ff @(posedge clock_in or posedge rst_in)
         begin
            if (rst_in)
               ctrl[i] <= `DCC_CTRL_RESET;
            else if (take_wr && ctrl_sel[i]
                     && avs_byteenable_in[0])
               ctrl[i] <= avs_writedata_in[7:0] & `DCC_CTRL_WMASK;
         end

         dcc_channel u_channel
         (
            .clock_in   (clock_in),
            .rst_in     (rst_in),
            .ctrl_in    (ctrl[i]),
            .raw_in     (raw_result_in[i]),
            .result_out (result[i]),
            .change_out (change[i])
         );

         // Power not tied to the core sleep state
         assign power_on_out[i] = ctrl[i].power_on;
         assign hyst_on_out[i]  = ctrl[i].hyst_on;

         // Output pin taken only on the external path
         assign result_pin_out[i]    = result[i];
         assign result_pin_oe_out[i] = ctrl[i].pin_claim
                                       & ~ctrl[i].out_path;

         // Claimed input pins lose pull-ups and normal reads
         assign pullup_en_out[2*i+1 -: 2] = pins[i].pullup_cfg
                                  & {2{~ctrl[i].pin_claim}};
         assign port_read_out[2*i+1 -: 2] = ctrl[i].pin_claim
                  ? pins[i].port_data & ~pins[i].port_ctrl
                  : pins[i].pin_level;
      end
   endgenerate

   assign sw_set = (take_wr && avs_address_in == `DCC_OFS_STATUS
                    && avs_byteenable_in[0]) ? avs_writedata_in[1:0] : 2'h0;
   // Only bits handed out are cleared, so a later set is never lost
   assign rd_clr = (take_rd && avs_address_in == `DCC_OFS_STATUS)
                   ? avs_readdata_out[1:0] : 2'h0;

   // Hardware set beats the clear of the same read
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
         status <= `DCC_STATUS_RESET;
      else
         status <= (status & ~rd_clr) | change | sw_set;
   end

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
         mask <= `DCC_MASK_RESET;
      else if (take_wr && avs_address_in == `DCC_OFS_MASK
               && avs_byteenable_in[0])
         mask <= avs_writedata_in[1:0];
   end

   assign irq_out = |(status & mask);

   // A flag already high blocks the wake-up
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
         wake_out <= 1'b0;
      else
         wake_out <= low_power_in
                     & |(change & ~status
                         & {ctrl[1].power_on, ctrl[0].power_on});
   end

   always_comb
   begin
      next_readdata = 32'h0;
      case (avs_address_in)
         `DCC_OFS_CTRL0:
         begin
            next_readdata[7:0] = ctrl[0];
            next_readdata[`DCC_BIT_RESULT] = result[0];
         end
         `DCC_OFS_CTRL1:
         begin
            next_readdata[7:0] = ctrl[1];
            next_readdata[`DCC_BIT_RESULT] = result[1];
         end
         `DCC_OFS_STATUS:
            next_readdata[1:0] = status;
         `DCC_OFS_MASK:
            next_readdata[1:0] = mask;
         default:
            next_readdata = 32'h0;
      endcase
   end

   // Captured on entry so data stands while waitrequest is low
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
         avs_readdata_out <= 32'h0;
      else if (load_rd)
         avs_readdata_out <= next_readdata;
   end

endmodule

/* sim/dcc_top_sva.sv */
// Port assertions for the comparator control block
module dcc_top_sva
(
   // Clock, reset, bus, core power state and wake
   input wire logic clock_in, rst_in, avs_read_in, avs_write_in,
   input wire logic avs_waitrequest_out, low_power_in, wake_out,
   input wire logic [4:0] avs_address_in,
   input wire logic [31:0] avs_readdata_out,
   // Comparators and pins
   input wire logic [1:0] raw_result_in, power_on_out, result_pin_out,
   input wire logic [1:0] result_pin_oe_out,
   input wire logic [3:0] port_read_out, pullup_en_out,
   input wire dcc_pkg::dcc_pins_t pins0_in, pins1_in
);
   import dcc_pkg::*;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);
   property p_wait;
      $rose(avs_read_in | avs_write_in) |->
         avs_waitrequest_out ##1 !avs_waitrequest_out;
   endproperty
   a_wait: assert property (p_wait) else $error("bus answer off time");
   property p_hold;
      !$past(avs_read_in & avs_waitrequest_out) |-> $stable(avs_readdata_out);
   endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_rsvd;
      avs_read_in && !avs_waitrequest_out && avs_address_in[4:3] == 2'h0 |->
         avs_readdata_out[31:8] == 24'h0 && avs_readdata_out[2:1] == 2'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("unused bits set");
   // Writes may flip the polarity, so they excuse a result change
   property p_sync;
      $changed(result_pin_out[0]) |-> $past(avs_write_in, 2) ||
         $past(raw_result_in[0], 3) != $past(raw_result_in[0], 4) ||
         $past(avs_write_in) || $past(rst_in, 4);
   endproperty
   a_sync: assert property (p_sync) else $error("result off time");
   property p_frz;
      $past(!power_on_out[1]) && !power_on_out[1] |->
         $stable(result_pin_out[1]);
   endproperty
   a_frz: assert property (p_frz) else $error("result moved off");
   property p_pull;
      (pullup_en_out & ~{pins1_in.pullup_cfg, pins0_in.pullup_cfg}) == 4'h0;
   endproperty
   a_pull: assert property (p_pull) else $error("stray pull-up");
   property p_oe;
      result_pin_oe_out[0] |-> pullup_en_out[1:0] == 2'h0 &&
         port_read_out[1:0] == (pins0_in.port_data & ~pins0_in.port_ctrl);
   endproperty
   a_oe: assert property (p_oe) else $error("claimed pins wrong");
   property p_wake;
      wake_out |-> $past(low_power_in) && $past(power_on_out) != 2'h0 &&
         result_pin_out != $past(result_pin_out);
   endproperty
   a_wake: assert property (p_wake) else $error("wake unprompted");
   cover property (avs_read_in && !avs_waitrequest_out);
   cover property (wake_out);
   cover property (result_pin_oe_out[0] && power_on_out[0]);
endmodule
bind dcc_top dcc_top_sva dcc_top_sva_i (.*);

/* sim/tb_dcc_top.sv */
// Self-checking bench for the comparator control block
module tb_dcc_top;
   timeunit 1ns;
   timeprecision 1ps;
   import dcc_pkg::*;
   logic clock_in, rst_in, avs_read_in, avs_write_in, low_power_in;
   logic avs_waitrequest_out, irq_out, wake_out, ewk, gwk;
   logic [1:0] raw_result_in, power_on_out, hyst_on_out, res, st, msk;
   logic [1:0] result_pin_out, result_pin_oe_out;
   logic [3:0] avs_byteenable_in, port_read_out, pullup_en_out;
   logic [4:0] avs_address_in;
   logic [31:0] avs_writedata_in, avs_readdata_out, q, e, r;
   logic [7:0] ctrl [2];
   dcc_pins_t pins0_in, pins1_in;
   int num_errors, n_compared, seed, it;
   dcc_top dcc_top_i (.*);
   initial
   begin
      clock_in = 1'b0;
      forever #2.5 clock_in = ~clock_in;
   end
   // Wake is a one-cycle pulse, so catch it between checks
   always @(negedge clock_in) if (wake_out === 1'b1) gwk = 1'b1;
   task end_sim;
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] x);
      n_compared++;
      if (g !== x)
      begin
         num_errors++;
         $display("unexpected at %0t: got %h exp %h", $time, g, x);
      end
   endtask
   task bus(input logic w, input logic [4:0] a, input logic [31:0] d,
            input logic [3:0] be);
      int k;
      k = 0;
      @(posedge clock_in);
      avs_address_in <= a;
      avs_write_in <= w;
      avs_read_in <= !w;
      avs_writedata_in <= d;
      avs_byteenable_in <= be;
      @(posedge clock_in);
      while (avs_waitrequest_out !== 1'b0 && k < 50)
      begin
         @(posedge clock_in);
         k++;
      end
      if (avs_waitrequest_out !== 1'b0)
      begin
         num_errors++;
         end_sim;
      end
      q = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
   endtask
   task wr(input logic [4:0] a, input logic [7:0] d);
      logic [31:0] wd;
      wd = $random(seed);
      wd[7:0] = d;
      bus(1'b1, a, wd, wd[11:8]);
      if (wd[8])
         case (a)
            5'h00: ctrl[0] = d;
            5'h04: ctrl[1] = d;
            5'h08: st = st | d[1:0];
            5'h0c: msk = d[1:0];
            default: ;
         endcase
   endtask
   task rd(input logic [4:0] a, input logic [31:0] x);
      bus(1'b0, a, 32'h0, 4'hf);
      chk(q, x);
   endtask
   task upd;
      for (int i = 0; i < 2; i++)
         if (ctrl[i][6] && (raw_result_in[i] ^ ctrl[i][5]) != res[i])
         begin
            res[i] = !res[i];
            ewk = ewk | (low_power_in & !st[i]);
            st[i] = 1'b1;
         end
   endtask
   function logic [1:0] pr(input dcc_pins_t p, input logic c);
      return c ? p.port_data & ~p.port_ctrl : p.pin_level;
   endfunction
   initial
   begin
      seed = 32'h898e;
      num_errors = 0;
      n_compared = 0;
      {rst_in, avs_read_in, avs_write_in, low_power_in} = 4'h8;
      {avs_address_in, avs_writedata_in, avs_byteenable_in} = '0;
      {raw_result_in, pins0_in, pins1_in} = '0;
      {ctrl[0], ctrl[1], res, st, msk, ewk, gwk} = {16'h8181, 8'h0};
      repeat (16) @(posedge clock_in);
      rst_in <= 1'b0;
      rd(5'h00, 32'h81);
      rd(5'h04, 32'h81);
      rd(5'h08, 32'h0);
      rd(5'h0c, 32'h0);
      rd(5'h10, 32'h0);
      chk(hyst_on_out, 2'h3);
      $display("reset test done");
      for (it = 0; it < 40; it++)
      begin
         gwk = 1'b0;
         ewk = 1'b0;
         wr(5'h0c, 8'($random(seed)));
         wr(5'h08, it[2] ? 8'h3 : 8'h0);
         r = $random(seed);
         @(posedge clock_in);
         raw_result_in <= r[1:0];
         low_power_in <= r[2];
         pins0_in <= r[15:8];
         pins1_in <= r[23:16];
         repeat (6) @(negedge clock_in);
         upd;
         wr({2'h0, it[0], 2'h0}, 8'($random(seed)));
         repeat (6) @(negedge clock_in);
         upd;
         chk(power_on_out, {ctrl[1][6], ctrl[0][6]});
         chk(hyst_on_out, {ctrl[1][0], ctrl[0][0]});
         chk(result_pin_out, res);
         e = {ctrl[1][7] & ~ctrl[1][3], ctrl[0][7] & ~ctrl[0][3]};
         chk(result_pin_oe_out, e);
         e = {pins1_in.pullup_cfg & {2{~ctrl[1][7]}},
              pins0_in.pullup_cfg & {2{~ctrl[0][7]}}};
         chk(pullup_en_out, e);
         e = {pr(pins1_in, ctrl[1][7]), pr(pins0_in, ctrl[0][7])};
         chk(port_read_out, e);
         chk(irq_out, |(st & msk));
         chk(gwk, ewk);
         rd(5'h00, (ctrl[0] & 8'he9) | {res[0], 4'h0});
         rd(5'h04, (ctrl[1] & 8'he9) | {res[1], 4'h0});
         rd(5'h08, st);
         st = 2'h0;
         $display("test %0d done", it);
      end
      end_sim;
   end
endmodule
